// ==== dpc_consts.svh ====
`ifndef DPC_CONSTS_SVH
`define DPC_CONSTS_SVH

// counter and event widths
`define DPC_CNT_W 40
`define DPC_LOAD_W 32
`define DPC_EVN_W 4
`define DPC_SETUP_W 32

// setup register field positions
`define DPC_EVT_LSB 0
`define DPC_EVT_MSB 7
`define DPC_QUAL_LSB 8
`define DPC_QUAL_MSB 15
`define DPC_USR_BIT 16
`define DPC_OS_BIT 17
`define DPC_EDGE_BIT 18
`define DPC_PC_BIT 19
`define DPC_INT_BIT 20
`define DPC_EN_BIT 22
`define DPC_INV_BIT 23
`define DPC_THR_LSB 24
`define DPC_THR_MSB 31

// writable bits of each setup register
`define DPC_SETUP0_MASK 32'hffff_ffff
`define DPC_SETUP1_MASK 32'hffbf_ffff

// register selector codes on the privileged access port
`define DPC_SEL_SETUP0 2'h0
`define DPC_SEL_SETUP1 2'h1
`define DPC_SEL_COUNT0 2'h2
`define DPC_SEL_COUNT1 2'h3

// reset values
`define DPC_SETUP_RST 32'h0000_0000
`define DPC_CNT_RST 40'h00_0000_0000

`endif

// ==== dpc_pkg.sv ====
`include "dpc_consts.svh"
package dpc_pkg;
    typedef struct packed {
        logic prev_cond;
    } dpc_qual_st_t;

    typedef struct packed {
        logic [`DPC_CNT_W-1:0] cnt;
        logic pin;
        logic irq;
    } dpc_ctr_st_t;

    typedef struct packed {
        logic [`DPC_SETUP_W-1:0] setup0;
        logic [`DPC_SETUP_W-1:0] setup1;
        logic reg_ack;
        logic reg_fault;
        logic [`DPC_CNT_W-1:0] reg_rdata;
        logic ucr_ack;
        logic ucr_fault;
        logic [`DPC_CNT_W-1:0] ucr_data;
    } dpc_top_st_t;

    // widen a written low word by copies of its top bit
    function automatic logic [`DPC_CNT_W-1:0] dpc_sext(input logic [`DPC_LOAD_W-1:0] v);
        dpc_sext = {{(`DPC_CNT_W - `DPC_LOAD_W){v[`DPC_LOAD_W-1]}}, v};
    endfunction
endpackage

// ==== dpc_inc_if.sv ====
`timescale 1ns/1ps
`include "dpc_consts.svh"
interface dpc_inc_if;
    logic [`DPC_EVN_W-1:0] inc;
    logic hit;
    modport src (output inc, output hit);
    modport dst (input inc, input hit);
endinterface

// ==== dpc_qual.sv ====
`timescale 1ns/1ps
`include "dpc_consts.svh"
module dpc_qual (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [`DPC_SETUP_W-1:0] setup,
    input wire logic global_en,
    input wire logic [1:0] cpl,
    input wire logic [`DPC_EVN_W-1:0] ev_cnt,
    dpc_inc_if.src inc_o
);
    dpc_pkg::dpc_qual_st_t st_q;
    dpc_pkg::dpc_qual_st_t st_d;
    logic [7:0] thr;
    logic priv_ok;
    logic active;
    logic cond;

    // privilege filter, threshold compare and edge detect
    always_comb begin
        st_d = st_q;
        thr = setup[`DPC_THR_MSB:`DPC_THR_LSB];
        priv_ok = (cpl == 2'h0) ? setup[`DPC_OS_BIT] : setup[`DPC_USR_BIT];
        active = global_en && (setup != `DPC_SETUP_RST) && priv_ok;
        if (thr == 8'h00) begin
            cond = (ev_cnt != 4'h0);
        end else begin
            cond = ({4'h0, ev_cnt} >= thr) ^ setup[`DPC_INV_BIT];
        end
        st_d.prev_cond = active && cond;
        if (!active || !cond) begin
            inc_o.inc = 4'h0;
        end else if (setup[`DPC_EDGE_BIT]) begin
            inc_o.inc = st_q.prev_cond ? 4'h0 : 4'h1;
        end else if (thr == 8'h00) begin
            inc_o.inc = ev_cnt;
        end else begin
            inc_o.inc = 4'h1;
        end
        inc_o.hit = (inc_o.inc != 4'h0);
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    property p_thr_one;
        (thr != 8'h00) |-> (inc_o.inc <= 4'h1);
    endproperty
    a_thr_one: assert property (p_thr_one) else $error("threshold mode added more than one");

    property p_edge_once;
        (setup[`DPC_EDGE_BIT] && inc_o.hit) |=> (setup != $past(setup)) || (inc_o.inc == 4'h0);
    endproperty
    a_edge_once: assert property (p_edge_once) else $error("edge mode counted a held condition twice");

    property p_inv;
        (active && thr != 8'h00 && !setup[`DPC_EDGE_BIT] && setup[`DPC_INV_BIT])
            |-> (inc_o.hit == ({4'h0, ev_cnt} < thr));
    endproperty
    a_inv: assert property (p_inv) else $error("inverted compare gave wrong result");
endmodule

// ==== dpc_ctr.sv ====
`timescale 1ns/1ps
`include "dpc_consts.svh"
module dpc_ctr (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic load,
    input wire logic [`DPC_LOAD_W-1:0] load_val,
    input wire logic pin_sel,
    input wire logic irq_en,
    dpc_inc_if.dst inc_i,
    output logic [`DPC_CNT_W-1:0] count,
    output logic pin,
    output logic irq
);
    dpc_pkg::dpc_ctr_st_t st_q;
    dpc_pkg::dpc_ctr_st_t st_d;
    logic [`DPC_CNT_W:0] sum;
    logic ovf;

    // add, load and overflow detect
    always_comb begin
        st_d = st_q;
        sum = {1'b0, st_q.cnt} + {{(`DPC_CNT_W + 1 - `DPC_EVN_W){1'b0}}, inc_i.inc};
        ovf = !load && sum[`DPC_CNT_W];
        if (load) begin
            st_d.cnt = dpc_pkg::dpc_sext(load_val);
        end else begin
            st_d.cnt = sum[`DPC_CNT_W-1:0];
        end
        st_d.pin = (pin_sel ? inc_i.hit : ovf) && !st_q.pin;
        st_d.irq = ovf && irq_en;
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign count = st_q.cnt;
    assign pin = st_q.pin;
    assign irq = st_q.irq;

    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    property p_pin_pulse;
        pin |=> !pin;
    endproperty
    a_pin_pulse: assert property (p_pin_pulse) else $error("monitor pin held past one clock");

    property p_wrap;
        (!load && st_q.cnt == {`DPC_CNT_W{1'b1}} && inc_i.hit) |=> (count < 40'h00_0000_0010) && (irq == $past(irq_en));
    endproperty
    a_wrap: assert property (p_wrap) else $error("wrap did not flag overflow");

    property p_add;
        !load |=> count == $past(count) + {36'h0_0000_0000, $past(inc_i.inc)};
    endproperty
    a_add: assert property (p_add) else $error("counter did not add the qualified amount");

    property p_ovf_pin;
        (!pin_sel && !load && !pin && st_q.cnt == {`DPC_CNT_W{1'b1}} && inc_i.hit) |=> pin ##1 !pin;
    endproperty
    a_ovf_pin: assert property (p_ovf_pin) else $error("overflow pulse missing on pin");
endmodule

// ==== dpc_top.sv ====
// Operation
// - two independent 40-bit counters, counting events or measuring durations
// - duration mode adds one per clock while the selected condition holds
// - setup bits 7..0 choose the event detection unit feeding the counter
// - setup bits 15..8 further qualify the selected event
// - bit 16 counts at privilege levels 1 to 3, combinable with bit 17
// - bit 17 counts at privilege level 0, combinable with bit 16
// - bit 18 counts only rising transitions; held assertions count once
// - bit 19 pulses the pin per counted event, else only on overflow; no pulse in the clock right after a pulse
// - a pin pulse is high for exactly one bus clock, then low
// - bit 20 raises an interrupt request on counter overflow
// - bit 22 exists only in setup zero and enables both counters
// - bit 23 inverts the threshold compare, counting below threshold
// - nonzero threshold adds exactly one when per-cycle count reaches it
// - zero threshold adds the per-cycle event count
// - counter writes load low 32 bits, upper 8 copy bit 31
// - unprivileged read allowed anywhere unless permit flag limits it to level 0
// - privileged register access allowed only at privilege level 0
// - counting starts right after the write setting the enable completes
// - both stop when enable clears or both setups are all zero
// - clearing setup one stops only counter one
// - unprivileged read is not serializing; it samples without waiting
`timescale 1ns/1ps
`include "dpc_consts.svh"
module dpc_top (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [1:0] cpl,
    input wire logic user_counter_read_permit,
    input wire logic [`DPC_EVN_W-1:0] ev_cnt_zero,
    input wire logic [`DPC_EVN_W-1:0] ev_cnt_one,
    input wire logic reg_req,
    input wire logic reg_write,
    input wire logic [1:0] reg_sel,
    input wire logic [`DPC_CNT_W-1:0] reg_wdata,
    output logic reg_ack,
    output logic reg_fault,
    output logic [`DPC_CNT_W-1:0] reg_rdata,
    input wire logic ucr_req,
    input wire logic ucr_sel,
    output logic ucr_ack,
    output logic ucr_fault,
    output logic [`DPC_CNT_W-1:0] ucr_data,
    output logic [7:0] event_code_zero,
    output logic [7:0] event_qualifier_field_zero,
    output logic [7:0] event_code_one,
    output logic [7:0] event_qualifier_field_one,
    output logic [1:0] monitor_output_pins,
    output logic [1:0] ovf_irq
);
    dpc_pkg::dpc_top_st_t st_q;
    dpc_pkg::dpc_top_st_t st_d;
    logic priv0;
    logic wr;
    logic ld0;
    logic ld1;
    logic ucr_ok;
    logic [`DPC_CNT_W-1:0] count_zero;
    logic [`DPC_CNT_W-1:0] count_one;
    logic pin0;
    logic pin1;
    logic irq0;
    logic irq1;

    dpc_inc_if inc0 ();
    dpc_inc_if inc1 ();

    // privileged access qualification and counter loads
    assign priv0 = (cpl == 2'h0);
    assign wr = reg_req && reg_write && priv0;
    assign ld0 = wr && (reg_sel == `DPC_SEL_COUNT0);
    assign ld1 = wr && (reg_sel == `DPC_SEL_COUNT1);
    assign ucr_ok = !user_counter_read_permit || priv0;

    // register file, privileged port and unprivileged read path
    always_comb begin
        st_d = st_q;
        st_d.reg_ack = reg_req;
        st_d.reg_fault = reg_req && !priv0;
        st_d.reg_rdata = `DPC_CNT_RST;
        if (reg_req && priv0 && !reg_write) begin
            case (reg_sel)
                `DPC_SEL_SETUP0: begin
                    st_d.reg_rdata = {8'h00, st_q.setup0};
                end
                `DPC_SEL_SETUP1: begin
                    st_d.reg_rdata = {8'h00, st_q.setup1};
                end
                `DPC_SEL_COUNT0: begin
                    st_d.reg_rdata = count_zero;
                end
                default: begin
                    st_d.reg_rdata = count_one;
                end
            endcase
        end
        // setup writes take effect at the next edge, so counting starts right after
        if (wr && reg_sel == `DPC_SEL_SETUP0) begin
            st_d.setup0 = reg_wdata[`DPC_SETUP_W-1:0] & `DPC_SETUP0_MASK;
        end
        if (wr && reg_sel == `DPC_SEL_SETUP1) begin
            st_d.setup1 = reg_wdata[`DPC_SETUP_W-1:0] & `DPC_SETUP1_MASK;
        end
        // sampled straight from the counters with no wait on anything else
        st_d.ucr_ack = ucr_req;
        st_d.ucr_fault = ucr_req && !ucr_ok;
        st_d.ucr_data = `DPC_CNT_RST;
        if (ucr_req && ucr_ok) begin
            st_d.ucr_data = ucr_sel ? count_one : count_zero;
        end
    end

    // state register
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // qualification of each event source
    dpc_qual u_qual0 (
        .ref_clk(ref_clk),
        .reset(reset),
        .setup(st_q.setup0),
        .global_en(st_q.setup0[`DPC_EN_BIT]),
        .cpl(cpl),
        .ev_cnt(ev_cnt_zero),
        .inc_o(inc0.src)
    );

    dpc_qual u_qual1 (
        .ref_clk(ref_clk),
        .reset(reset),
        .setup(st_q.setup1),
        .global_en(st_q.setup0[`DPC_EN_BIT]),
        .cpl(cpl),
        .ev_cnt(ev_cnt_one),
        .inc_o(inc1.src)
    );

    // the two counters with their pin and interrupt logic
    dpc_ctr u_ctr0 (
        .ref_clk(ref_clk),
        .reset(reset),
        .load(ld0),
        .load_val(reg_wdata[`DPC_LOAD_W-1:0]),
        .pin_sel(st_q.setup0[`DPC_PC_BIT]),
        .irq_en(st_q.setup0[`DPC_INT_BIT]),
        .inc_i(inc0.dst),
        .count(count_zero),
        .pin(pin0),
        .irq(irq0)
    );

    dpc_ctr u_ctr1 (
        .ref_clk(ref_clk),
        .reset(reset),
        .load(ld1),
        .load_val(reg_wdata[`DPC_LOAD_W-1:0]),
        .pin_sel(st_q.setup1[`DPC_PC_BIT]),
        .irq_en(st_q.setup1[`DPC_INT_BIT]),
        .inc_i(inc1.dst),
        .count(count_one),
        .pin(pin1),
        .irq(irq1)
    );

    // outputs, all from flip-flops
    assign reg_ack = st_q.reg_ack;
    assign reg_fault = st_q.reg_fault;
    assign reg_rdata = st_q.reg_rdata;
    assign ucr_ack = st_q.ucr_ack;
    assign ucr_fault = st_q.ucr_fault;
    assign ucr_data = st_q.ucr_data;
    assign event_code_zero = st_q.setup0[`DPC_EVT_MSB:`DPC_EVT_LSB];
    assign event_qualifier_field_zero = st_q.setup0[`DPC_QUAL_MSB:`DPC_QUAL_LSB];
    assign event_code_one = st_q.setup1[`DPC_EVT_MSB:`DPC_EVT_LSB];
    assign event_qualifier_field_one = st_q.setup1[`DPC_QUAL_MSB:`DPC_QUAL_LSB];
    assign monitor_output_pins = {pin1, pin0};
    assign ovf_irq = {irq1, irq0};

    default clocking @(posedge ref_clk); endclocking
    default disable iff (reset);

    property p_priv_fault;
        (reg_req && cpl != 2'h0) |=> reg_ack && reg_fault && (reg_rdata == 40'h00_0000_0000);
    endproperty
    a_priv_fault: assert property (p_priv_fault) else $error("access above level 0 not refused");

    property p_priv_nowrite;
        (reg_req && reg_write && cpl != 2'h0 && reg_sel == `DPC_SEL_SETUP0) |=> $stable(st_q.setup0);
    endproperty
    a_priv_nowrite: assert property (p_priv_nowrite) else $error("setup written above level 0");

    property p_ucr_perm;
        ucr_req |=> ucr_ack && (ucr_fault == ($past(user_counter_read_permit) && $past(cpl) != 2'h0));
    endproperty
    a_ucr_perm: assert property (p_ucr_perm) else $error("unprivileged read permission wrong");

    property p_sext;
        ld0 |=> count_zero == dpc_pkg::dpc_sext($past(reg_wdata[`DPC_LOAD_W-1:0]));
    endproperty
    a_sext: assert property (p_sext) else $error("counter load not sign extended");

    property p_en_only0;
        st_q.setup1[`DPC_EN_BIT] == 1'b0;
    endproperty
    a_en_only0: assert property (p_en_only0) else $error("enable bit present in setup one");

    property p_stop;
        (!st_q.setup0[`DPC_EN_BIT] && !ld0 && !ld1) |=> $stable(count_zero) && $stable(count_one);
    endproperty
    a_stop: assert property (p_stop) else $error("counter moved while disabled");

    property p_stop_one;
        (st_q.setup1 == `DPC_SETUP_RST && !ld1) |=> $stable(count_one);
    endproperty
    a_stop_one: assert property (p_stop_one) else $error("counter one moved with empty setup");

    property p_ucr_data;
        (ucr_req && ucr_ok && !ucr_sel) |=> ucr_data == $past(count_zero);
    endproperty
    a_ucr_data: assert property (p_ucr_data) else $error("unprivileged read returned wrong value");

    property p_ack;
        reg_req |=> reg_ack;
    endproperty
    a_ack: assert property (p_ack) else $error("access not acknowledged");

    property p_no_ack;
        !reg_req |=> !reg_ack && !reg_fault;
    endproperty
    a_no_ack: assert property (p_no_ack) else $error("answer without a request");

    property p_rd_setup0;
        (reg_req && !reg_write && priv0 && reg_sel == `DPC_SEL_SETUP0)
            |=> reg_rdata == {8'h00, $past(st_q.setup0)};
    endproperty
    a_rd_setup0: assert property (p_rd_setup0) else $error("setup zero read back wrong");

    property p_rd_count1;
        (reg_req && !reg_write && priv0 && reg_sel == `DPC_SEL_COUNT1) |=> reg_rdata == $past(count_one);
    endproperty
    a_rd_count1: assert property (p_rd_count1) else $error("counter one read back wrong");

    property p_wr_zero;
        (reg_req && reg_write) |=> reg_rdata == 40'h00_0000_0000;
    endproperty
    a_wr_zero: assert property (p_wr_zero) else $error("write answered with data");

    property p_setup0_wr;
        (reg_req && reg_write && priv0 && reg_sel == `DPC_SEL_SETUP0)
            |=> st_q.setup0 == $past(reg_wdata[`DPC_SETUP_W-1:0]);
    endproperty
    a_setup0_wr: assert property (p_setup0_wr) else $error("setup zero write did not land");

    property p_sext1;
        ld1 |=> count_one == dpc_pkg::dpc_sext($past(reg_wdata[`DPC_LOAD_W-1:0]));
    endproperty
    a_sext1: assert property (p_sext1) else $error("counter one load not sign extended");

    property p_ucr_refuse;
        (ucr_req && user_counter_read_permit && !priv0) |=> ucr_fault && (ucr_data == 40'h00_0000_0000);
    endproperty
    a_ucr_refuse: assert property (p_ucr_refuse) else $error("restricted user read not refused");

    property p_ucr_data1;
        (ucr_req && ucr_ok && ucr_sel) |=> ucr_data == $past(count_one);
    endproperty
    a_ucr_data1: assert property (p_ucr_data1) else $error("user read of counter one wrong");

    property p_start;
        (st_q.setup0[`DPC_EN_BIT] && st_q.setup0[`DPC_OS_BIT] && !st_q.setup0[`DPC_EDGE_BIT] && priv0
            && st_q.setup0[`DPC_THR_MSB:`DPC_THR_LSB] == 8'h00 && !ld0)
            |=> count_zero == $past(count_zero) + {36'h0_0000_0000, $past(ev_cnt_zero)};
    endproperty
    a_start: assert property (p_start) else $error("enabled counter did not add the events");

    property p_irq_wrap0;
        (count_zero < 40'hff_ffff_fff0) |=> !ovf_irq[0];
    endproperty
    a_irq_wrap0: assert property (p_irq_wrap0) else $error("interrupt zero without a wrap");

    property p_irq_wrap1;
        (count_one < 40'hff_ffff_fff0) |=> !ovf_irq[1];
    endproperty
    a_irq_wrap1: assert property (p_irq_wrap1) else $error("interrupt one without a wrap");

    property p_pin_idle;
        !st_q.setup0[`DPC_EN_BIT] |=> monitor_output_pins == 2'h0;
    endproperty
    a_pin_idle: assert property (p_pin_idle) else $error("monitor pin pulsed while disabled");

    property p_irq_off0;
        !st_q.setup0[`DPC_INT_BIT] |=> !ovf_irq[0];
    endproperty
    a_irq_off0: assert property (p_irq_off0) else $error("interrupt zero raised while masked");

    property p_irq_off1;
        !st_q.setup1[`DPC_INT_BIT] |=> !ovf_irq[1];
    endproperty
    a_irq_off1: assert property (p_irq_off1) else $error("interrupt one raised while masked");
endmodule

// ==== dpc_evsrc.sv ====
`timescale 1ns/1ps
`include "dpc_consts.svh"
module dpc_evsrc (
    output logic [1:0] cpl,
    output logic [`DPC_EVN_W-1:0] ev_cnt_zero,
    output logic [`DPC_EVN_W-1:0] ev_cnt_one
);
    // processor side: privilege level and per-cycle event counts, idle at zero
    initial begin
        cpl = 2'h0;
        ev_cnt_zero = 4'h0;
        ev_cnt_one = 4'h0;
    end

    // caller drives just after a rising edge; a held value is a duration condition
    task automatic drive(input logic [1:0] lvl, input logic [3:0] e0, input logic [3:0] e1);
        cpl = lvl;
        ev_cnt_zero = e0;
        ev_cnt_one = e1;
    endtask
endmodule

// ==== testbench.sv ====
`timescale 1ns/1ps
`include "dpc_consts.svh"
module testbench;
    typedef struct packed {
        logic [31:0] setup;
        logic [3:0] ev;
        logic [1:0] lvl;
        logic [7:0] n;
        logic [39:0] want;
    } dpc_row_t;
    logic ref_clk;
    logic reset;
    logic [1:0] cpl;
    logic permit;
    logic [3:0] ev_cnt_zero;
    logic [3:0] ev_cnt_one;
    logic reg_req;
    logic reg_write;
    logic [1:0] reg_sel;
    logic [39:0] reg_wdata;
    logic reg_ack;
    logic reg_fault;
    logic [39:0] reg_rdata;
    logic ucr_req;
    logic ucr_sel;
    logic ucr_ack;
    logic ucr_fault;
    logic [39:0] ucr_data;
    logic [7:0] code0;
    logic [7:0] qual0;
    logic [7:0] code1;
    logic [7:0] qual1;
    logic [1:0] pins;
    logic [1:0] irq;
    logic pin_prev;
    int mismatches;
    int checks_done;
    int cycles;
    int pin_hits;
    int irq_hits;
    int pin1_hits;
    int irq1_hits;
    int pin_twice;
    int p0;
    int i0;
    dpc_row_t rows [11];

    dpc_evsrc u_src (.cpl(cpl), .ev_cnt_zero(ev_cnt_zero), .ev_cnt_one(ev_cnt_one));

    dpc_top u_dut (
        .ref_clk(ref_clk), .reset(reset), .cpl(cpl), .user_counter_read_permit(permit),
        .ev_cnt_zero(ev_cnt_zero), .ev_cnt_one(ev_cnt_one), .reg_req(reg_req),
        .reg_write(reg_write), .reg_sel(reg_sel), .reg_wdata(reg_wdata), .reg_ack(reg_ack),
        .reg_fault(reg_fault), .reg_rdata(reg_rdata), .ucr_req(ucr_req), .ucr_sel(ucr_sel),
        .ucr_ack(ucr_ack), .ucr_fault(ucr_fault), .ucr_data(ucr_data), .event_code_zero(code0),
        .event_qualifier_field_zero(qual0), .event_code_one(code1), .event_qualifier_field_one(qual1),
        .monitor_output_pins(pins), .ovf_irq(irq)
    );

    // clock
    initial begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    // pin and interrupt pulse tally, plus the run ceiling
    always @(posedge ref_clk) begin
        cycles++;
        if (pins[0] === 1'b1) pin_hits++;
        if (pins[0] === 1'b1 && pin_prev === 1'b1) pin_twice++;
        if (irq[0] === 1'b1) irq_hits++;
        if (pins[1] === 1'b1) pin1_hits++;
        if (irq[1] === 1'b1) irq1_hits++;
        pin_prev = pins[0];
        if (cycles == 3000) begin
            mismatches++;
            tally_and_finish();
        end
    end

    task automatic chk(input logic [39:0] seen, input logic [39:0] want, input string what);
        checks_done++;
        if (seen !== want) begin
            mismatches++;
            $display("BAD %0t %s seen %h want %h", $time, what, seen, want);
        end
    endtask

    // one privileged access; answer checked one edge later, request left up for the next access
    task automatic reg_op(input logic wr, input logic [1:0] sel, input logic [39:0] wd,
                          input logic flt, input logic [39:0] rd);
        reg_req = 1'b1;
        reg_write = wr;
        reg_sel = sel;
        reg_wdata = wd;
        @(posedge ref_clk);
        #1;
        chk({39'h0, reg_ack}, 40'h1, "reg ack");
        chk({39'h0, reg_fault}, {39'h0, flt}, "reg fault");
        chk(reg_rdata, rd, "reg data");
    endtask

    task automatic ucr_op(input logic sel, input logic flt, input logic [39:0] rd);
        ucr_req = 1'b1;
        ucr_sel = sel;
        @(posedge ref_clk);
        #1;
        chk({39'h0, ucr_ack}, 40'h1, "ucr ack");
        chk({39'h0, ucr_fault}, {39'h0, flt}, "ucr fault");
        chk(ucr_data, rd, "ucr data");
    endtask

    // preset counter zero, enable with a setup, hold events n cycles, then stop
    task automatic run_row(input logic [39:0] start, input logic [31:0] setup, input logic [3:0] ev,
                           input logic [1:0] lvl, input logic [7:0] n);
        reg_op(1'b1, `DPC_SEL_COUNT0, start, 1'b0, 40'h0);
        u_src.drive(2'h0, ev, 4'h0);
        reg_op(1'b1, `DPC_SEL_SETUP0, {8'h0, setup}, 1'b0, 40'h0);
        chk({24'h0, qual0, code0}, {24'h0, setup[15:0]}, "fields");
        u_src.drive(lvl, ev, 4'h0);
        repeat (n) @(posedge ref_clk);
        #1;
        u_src.drive(2'h0, 4'h0, 4'h0);
        reg_op(1'b1, `DPC_SEL_SETUP0, 40'h0, 1'b0, 40'h0);
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        reset = 1'b1;
        permit = 1'b0;
        reg_req = 1'b0;
        reg_write = 1'b0;
        reg_sel = 2'h0;
        reg_wdata = 40'h0;
        ucr_req = 1'b0;
        ucr_sel = 1'b0;
        rows = '{'{32'h0042_a55a, 4'h3, 2'h0, 8'd4, 40'd12}, '{32'h0041_0000, 4'h3, 2'h0, 8'd4, 40'd0},
                 '{32'h0041_0012, 4'h2, 2'h3, 8'd5, 40'd10}, '{32'h0042_0000, 4'h2, 2'h2, 8'd4, 40'd0},
                 '{32'h0002_0000, 4'h3, 2'h0, 8'd4, 40'd0}, '{32'h0242_0000, 4'h3, 2'h0, 8'd4, 40'd4},
                 '{32'h0442_0000, 4'h3, 2'h0, 8'd4, 40'd0}, '{32'h04c2_0000, 4'h3, 2'h0, 8'd4, 40'd5},
                 '{32'h0046_0000, 4'h1, 2'h0, 8'd6, 40'd1}, '{32'h00c2_0000, 4'h2, 2'h0, 8'd3, 40'd6},
                 '{32'h0043_0000, 4'h1, 2'h1, 8'd3, 40'd3}};
        repeat (5) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        // all registers read zero after reset
        for (int i = 0; i < 4; i++) reg_op(1'b0, i[1:0], 40'h0, 1'b0, 40'h0);
        // table: privilege flags, enable, threshold, invert, edge detect
        foreach (rows[i]) begin
            run_row(40'h0, rows[i].setup, rows[i].ev, rows[i].lvl, rows[i].n);
            reg_op(1'b0, `DPC_SEL_COUNT0, 40'h0, 1'b0, rows[i].want);
        end
        // counter loads widen bit 31; setup one drops the enable bit
        reg_op(1'b1, `DPC_SEL_COUNT0, 40'h00_8000_0001, 1'b0, 40'h0);
        reg_op(1'b0, `DPC_SEL_COUNT0, 40'h0, 1'b0, 40'hff_8000_0001);
        reg_op(1'b1, `DPC_SEL_COUNT1, 40'hab_7fff_ffff, 1'b0, 40'h0);
        reg_op(1'b0, `DPC_SEL_COUNT1, 40'h0, 1'b0, 40'h00_7fff_ffff);
        reg_op(1'b1, `DPC_SEL_SETUP1, 40'hff_ffff_ffff, 1'b0, 40'h0);
        reg_op(1'b0, `DPC_SEL_SETUP1, 40'h0, 1'b0, {8'h0, `DPC_SETUP1_MASK});
        chk({24'h0, qual1, code1}, 40'h00_0000_ffff, "fields one");
        reg_op(1'b1, `DPC_SEL_SETUP1, 40'h0, 1'b0, 40'h0);
        // privilege: refused access changes nothing; user read follows the permit flag
        u_src.drive(2'h3, 4'h0, 4'h0);
        reg_op(1'b0, `DPC_SEL_COUNT0, 40'h0, 1'b1, 40'h0);
        reg_op(1'b1, `DPC_SEL_COUNT0, 40'h5, 1'b1, 40'h0);
        reg_op(1'b1, `DPC_SEL_SETUP0, 40'h0040_0000, 1'b1, 40'h0);
        reg_req = 1'b0;
        ucr_op(1'b0, 1'b0, 40'hff_8000_0001);
        permit = 1'b1;
        ucr_op(1'b1, 1'b1, 40'h0);
        u_src.drive(2'h0, 4'h0, 4'h0);
        ucr_op(1'b1, 1'b0, 40'h00_7fff_ffff);
        ucr_req = 1'b0;
        permit = 1'b0;
        reg_op(1'b0, `DPC_SEL_COUNT0, 40'h0, 1'b0, 40'hff_8000_0001);
        reg_op(1'b0, `DPC_SEL_SETUP0, 40'h0, 1'b0, 40'h0);
        // overflow from all ones: one pin pulse and one interrupt pulse
        p0 = pin_hits;
        i0 = irq_hits;
        run_row(40'hffff_ffff, 32'h0052_0000, 4'h1, 2'h0, 8'd1);
        reg_op(1'b0, `DPC_SEL_COUNT0, 40'h0, 1'b0, 40'h0);
        chk(40'(pin_hits - p0), 40'd1, "ovf pin");
        chk(40'(irq_hits - i0), 40'd1, "ovf irq");
        // pin on every other of four back-to-back counted events, never high two cycles running
        p0 = pin_hits;
        i0 = irq_hits;
        run_row(40'h0, 32'h004a_0000, 4'h1, 2'h0, 8'd4);
        chk(40'(pin_hits - p0), 40'd2, "event pins");
        chk(40'(irq_hits - i0), 40'd0, "no irq");
        chk(40'(pin_twice), 40'd0, "pin width");
        // clearing setup one stops only counter one; counter one wraps once with an interrupt and pulses its pin on every other counted event
        p0 = pin1_hits;
        i0 = irq1_hits;
        reg_op(1'b1, `DPC_SEL_COUNT0, 40'h0, 1'b0, 40'h0);
        reg_op(1'b1, `DPC_SEL_COUNT1, 40'hffff_ffff, 1'b0, 40'h0);
        reg_op(1'b1, `DPC_SEL_SETUP1, 40'h001a_0000, 1'b0, 40'h0);
        u_src.drive(2'h0, 4'h1, 4'h3);
        reg_op(1'b1, `DPC_SEL_SETUP0, 40'h0042_0000, 1'b0, 40'h0);
        repeat (3) @(posedge ref_clk);
        #1;
        reg_op(1'b1, `DPC_SEL_SETUP1, 40'h0, 1'b0, 40'h0);
        repeat (3) @(posedge ref_clk);
        #1;
        reg_op(1'b1, `DPC_SEL_SETUP0, 40'h0, 1'b0, 40'h0);
        reg_op(1'b0, `DPC_SEL_COUNT0, 40'h0, 1'b0, 40'd8);
        ucr_op(1'b1, 1'b0, 40'd11);
        chk(40'(pin1_hits - p0), 40'd2, "pins one");
        chk(40'(irq1_hits - i0), 40'd1, "irq one");
        u_src.drive(2'h0, 4'h0, 4'h0);
        // second reset in mid-run clears everything
        reset = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
        reset = 1'b0;
        reg_op(1'b0, `DPC_SEL_COUNT1, 40'h0, 1'b0, 40'h0);
        reg_op(1'b0, `DPC_SEL_SETUP1, 40'h0, 1'b0, 40'h0);
        tally_and_finish();
    end
endmodule
